// File: svmon_defs.svh
`ifndef SVMON_DEFS_SVH
`define SVMON_DEFS_SVH

// register indices on the 2-bit address port
`define SVMON_ADDR_CTRL 2'h0
`define SVMON_ADDR_STAT 2'h1
`define SVMON_ADDR_MASK 2'h2

// supply_monitor_ctrl field positions
`define SVMON_TRIP_MSB 2
`define SVMON_TRIP_LSB 0
`define SVMON_ON_BIT 4
`define SVMON_FLAG_BIT 5
`define SVMON_TRIP_RESET 3'h0
`define SVMON_ON_RESET 1'h0

// status and mask layout
`define SVMON_ST_IRQ 0
`define SVMON_ST_SETTLED 1
`define SVMON_ST_W 2
`define SVMON_STAT_RESET 2'h0
`define SVMON_MASK_RESET 2'h0

// timing
`define SVMON_CLK_MHZ 250
`define SVMON_SETTLE_US 150
`define SVMON_IRQ_DELAY_US 45
`define SVMON_US_TO_CYC(us) ((us) * `SVMON_CLK_MHZ)
`define SVMON_CNT_ONE 24'h000001
`define SVMON_CNT_ZERO 24'h000000

`endif

// File: svmon_pkg.sv
package svmon_pkg;

    typedef logic [23:0] svmon_cnt_t;

    typedef enum logic [1:0]
    {
        DLY_WAIT_HIGH = 2'b00,
        DLY_COUNT = 2'b01,
        DLY_FIRED = 2'b10
    } svmon_dly_state_t;

    typedef enum logic [1:0]
    {
        SET_OFF = 2'b00,
        SET_SETTLING = 2'b01,
        SET_READY = 2'b10
    } svmon_settle_state_t;

    typedef struct packed
    {
        logic sync1;
        logic sync2;
        logic lowv;
        logic evt;
        svmon_dly_state_t dstate;
        svmon_cnt_t cnt;
    } svmon_filt_state_t;

    typedef struct packed
    {
        logic [2:0] trip;
        logic det_on;
        logic det_en;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [7:0] rdata;
        svmon_settle_state_t sstate;
        svmon_cnt_t scnt;
        logic wake;
        logic irq;
        logic mf;
    } svmon_top_state_t;

endpackage : svmon_pkg

// File: svmon_det_if.sv
`timescale 1ns/100ps
interface svmon_det_if;
    logic det_en;
    logic lowv;
    logic delayed_evt;

    modport filt
    (
        input det_en,
        output lowv,
        output delayed_evt
    );

    modport ctrl
    (
        output det_en,
        input lowv,
        input delayed_evt
    );
endinterface : svmon_det_if

// File: svmon_cmp_filter.sv
`timescale 1ns/100ps
`include "svmon_defs.svh"
module svmon_cmp_filter #(
    parameter svmon_pkg::svmon_cnt_t IRQ_DELAY_CYCLES = 24'(`SVMON_US_TO_CYC(`SVMON_IRQ_DELAY_US))
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // analog comparator, asynchronous
    input wire logic cmp_async,
    // towards the register side
    svmon_det_if.filt det
);

    svmon_pkg::svmon_filt_state_t s;
    svmon_pkg::svmon_filt_state_t next_s;

    always_comb
    begin
        next_s = s;
        next_s.sync1 = cmp_async;
        next_s.sync2 = s.sync1;
        // a disabled detector may float its output, so force a clean low
        next_s.lowv = s.sync2 & det.det_en;
        next_s.evt = 1'b0;
        case (s.dstate)
            svmon_pkg::DLY_WAIT_HIGH:
            begin
                if (s.lowv)
                begin
                    next_s.cnt = `SVMON_CNT_ONE;
                    next_s.dstate = svmon_pkg::DLY_COUNT;
                end
            end
            svmon_pkg::DLY_COUNT:
            begin
                // a dip back above the level restarts the wait
                if (!s.lowv)
                begin
                    next_s.dstate = svmon_pkg::DLY_WAIT_HIGH;
                end
                else if (s.cnt >= IRQ_DELAY_CYCLES)
                begin
                    next_s.evt = 1'b1;
                    next_s.dstate = svmon_pkg::DLY_FIRED;
                end
                else
                begin
                    next_s.cnt = s.cnt + `SVMON_CNT_ONE;
                end
            end
            svmon_pkg::DLY_FIRED:
            begin
                if (!s.lowv)
                begin
                    next_s.dstate = svmon_pkg::DLY_WAIT_HIGH;
                end
            end
            default:
            begin
                next_s.dstate = svmon_pkg::DLY_WAIT_HIGH;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign det.lowv = s.lowv;
    assign det.delayed_evt = s.evt;

endmodule : svmon_cmp_filter

// File: svmon_top.sv
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
`include "svmon_defs.svh"
// How it works
// - writing detector_on 1 enables the detector; 0 switches it fully off
// - trip_level_sel bits 2..0 pick one of eight ascending levels, 1.8V to 4.0V
// - read-only lowv_flag at bit 5 shows supply below trip level
// - sleep forces the detector off whatever detector_on holds
// - lowv_irq_req sets only after irq_delay of lowv_flag staying high
// - lowv_irq_req feeds a shared multi-function interrupt, not its own vector
// - lowv_irq_req becoming set during idle produces a wake request
// - bits 7, 6 and 3 read zero and ignore writes
// - lowv_flag may toggle repeatedly near the trip level
module svmon_top #(
    parameter svmon_pkg::svmon_cnt_t SETTLE_CYCLES = 24'(`SVMON_US_TO_CYC(`SVMON_SETTLE_US)),
    parameter svmon_pkg::svmon_cnt_t IRQ_DELAY_CYCLES =
        24'(`SVMON_US_TO_CYC(`SVMON_IRQ_DELAY_US))
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // analog detector
    input wire logic cmp_async,
    output logic detector_enable,
    output logic [2:0] trip_level_sel,
    // power management
    input wire logic sleep_mode,
    input wire logic idle_mode,
    output logic wake_idle,
    // interrupts
    output logic irq,
    output logic mf_irq_req
);

    svmon_pkg::svmon_top_state_t s;
    svmon_pkg::svmon_top_state_t next_s;
    svmon_det_if det();
    logic [1:0] set_vec;
    logic [1:0] clr_vec;
    logic [7:0] ctrl_view;

    svmon_cmp_filter #(
        .IRQ_DELAY_CYCLES(IRQ_DELAY_CYCLES)
    ) u_filter (
        .clock(clock),
        .reset(reset),
        .cmp_async(cmp_async),
        .det(det.filt)
    );

    assign det.det_en = s.det_en;

    always_comb
    begin
        next_s = s;
        set_vec = `SVMON_STAT_RESET;
        clr_vec = `SVMON_STAT_RESET;
        ctrl_view = 8'h00;
        ctrl_view[`SVMON_TRIP_MSB:`SVMON_TRIP_LSB] = s.trip;
        ctrl_view[`SVMON_ON_BIT] = s.det_on;
        ctrl_view[`SVMON_FLAG_BIT] = det.lowv;

        if (reg_write)
        begin
            case (reg_addr)
                `SVMON_ADDR_CTRL:
                begin
                    // flag and unused bits are not stored
                    next_s.trip = reg_wdata[`SVMON_TRIP_MSB:`SVMON_TRIP_LSB];
                    next_s.det_on = reg_wdata[`SVMON_ON_BIT];
                end
                `SVMON_ADDR_STAT:
                begin
                    clr_vec = reg_wdata[`SVMON_ST_W-1:0];
                end
                `SVMON_ADDR_MASK:
                begin
                    next_s.mask = reg_wdata[`SVMON_ST_W-1:0];
                end
                default:
                begin
                    next_s.mask = s.mask;
                end
            endcase
        end

        // sleep overrides the enable
        next_s.det_en = next_s.det_on & ~sleep_mode;

        case (s.sstate)
            svmon_pkg::SET_OFF:
            begin
                if (s.det_en)
                begin
                    next_s.scnt = `SVMON_CNT_ONE;
                    next_s.sstate = svmon_pkg::SET_SETTLING;
                end
            end
            svmon_pkg::SET_SETTLING:
            begin
                if (!s.det_en)
                begin
                    next_s.sstate = svmon_pkg::SET_OFF;
                end
                else if (s.scnt >= SETTLE_CYCLES)
                begin
                    set_vec[`SVMON_ST_SETTLED] = 1'b1;
                    next_s.sstate = svmon_pkg::SET_READY;
                end
                else
                begin
                    next_s.scnt = s.scnt + `SVMON_CNT_ONE;
                end
            end
            svmon_pkg::SET_READY:
            begin
                if (!s.det_en)
                begin
                    next_s.sstate = svmon_pkg::SET_OFF;
                end
            end
            default:
            begin
                next_s.sstate = svmon_pkg::SET_OFF;
            end
        endcase

        set_vec[`SVMON_ST_IRQ] = det.delayed_evt;
        // set beats a simultaneous write-one clear
        next_s.stat = (s.stat & ~clr_vec) | set_vec;
        // only a 0 to 1 change wakes, so a pre-set flag suppresses it
        next_s.wake = det.delayed_evt & ~s.stat[`SVMON_ST_IRQ] & idle_mode;
        next_s.irq = |(next_s.stat & next_s.mask);
        next_s.mf = next_s.stat[`SVMON_ST_IRQ];

        next_s.rdata = 8'h00;
        if (reg_read)
        begin
            case (reg_addr)
                `SVMON_ADDR_CTRL:
                begin
                    next_s.rdata = ctrl_view;
                end
                `SVMON_ADDR_STAT:
                begin
                    next_s.rdata[`SVMON_ST_W-1:0] = s.stat;
                end
                `SVMON_ADDR_MASK:
                begin
                    next_s.rdata[`SVMON_ST_W-1:0] = s.mask;
                end
                default:
                begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            s <= '0;
            s.trip <= `SVMON_TRIP_RESET;
            s.det_on <= `SVMON_ON_RESET;
            s.stat <= `SVMON_STAT_RESET;
            s.mask <= `SVMON_MASK_RESET;
            s.scnt <= `SVMON_CNT_ZERO;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign detector_enable = s.det_en;
    assign trip_level_sel = s.trip;
    assign wake_idle = s.wake;
    assign irq = s.irq;
    assign mf_irq_req = s.mf;

endmodule : svmon_top

// File: svmon_top_sva.sv
`timescale 1ns/100ps
module svmon_top_chk #(
    parameter svmon_pkg::svmon_cnt_t SETTLE_CYCLES = 24'h000008,
    parameter svmon_pkg::svmon_cnt_t IRQ_DELAY_CYCLES = 24'h000005
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // detector and power
    input wire logic cmp_async,
    input wire logic detector_enable,
    input wire logic [2:0] trip_level_sel,
    input wire logic sleep_mode,
    input wire logic idle_mode,
    // requests
    input wire logic wake_idle,
    input wire logic irq,
    input wire logic mf_irq_req
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // saturates so a long low-supply spell cannot wrap back to zero
    svmon_pkg::svmon_cnt_t hi_cnt;
    always_ff @(posedge clock)
    begin
        if (reset || !cmp_async || !detector_enable)
            hi_cnt <= 24'h000000;
        else if (hi_cnt != 24'hffffff)
            hi_cnt <= hi_cnt + 24'h000001;
    end
    sequence s_ctrl_rd;
        reg_read && reg_addr == 2'h0;
    endsequence
    sequence s_off_rd;
        !detector_enable [*3] ##0 s_ctrl_rd;
    endsequence
    rdata_idle_a: assert property (
        !$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data outside reply");
    unused_bits_a: assert property (
        s_ctrl_rd |=> reg_rdata[7:6] == 2'h0 && !reg_rdata[3]) else $error("unused bits set");
    unmapped_zero_a: assert property (
        reg_read && reg_addr == 2'h3 |=> reg_rdata == 8'h00) else $error("unmapped read");
    trip_readback_a: assert property (
        s_ctrl_rd |=> reg_rdata[2:0] == $past(trip_level_sel)) else $error("trip mismatch");
    sleep_off_a: assert property (
        sleep_mode |=> !detector_enable) else $error("detector on in sleep");
    write_off_a: assert property (
        reg_write && reg_addr == 2'h0 && !reg_wdata[4] |-> ##[1:2] !detector_enable)
        else $error("detector not off");
    off_flag_a: assert property (
        s_off_rd |=> !reg_rdata[5]) else $error("flag set while off");
    irq_delay_a: assert property (
        $rose(mf_irq_req) |-> $past(hi_cnt, 3) >= IRQ_DELAY_CYCLES) else $error("early request");
    wake_cause_a: assert property (
        wake_idle |-> ##[0:1] $rose(mf_irq_req)) else $error("wake without request");
    wake_idle_a: assert property (
        !idle_mode [*2] |-> !wake_idle) else $error("wake outside idle");
    wake_pulse_a: assert property (
        wake_idle |=> !wake_idle) else $error("wake longer than a cycle");
endmodule : svmon_top_chk

// File: tb_svmon_top.sv
`timescale 1ns/100ps
module tb_svmon_top;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic cmp_async = 1'b0;
    logic sleep_mode = 1'b0;
    logic idle_mode = 1'b0;
    logic [7:0] reg_rdata;
    logic [2:0] trip_level_sel;
    logic detector_enable;
    logic wake_idle;
    logic irq;
    logic mf_irq_req;
    int err_count = 0;
    int n_tests = 0;
    int i;
    int n;
    svmon_top #(.SETTLE_CYCLES(24'h000008), .IRQ_DELAY_CYCLES(24'h000005)) u_dut (
        .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .cmp_async(cmp_async), .detector_enable(detector_enable),
        .trip_level_sel(trip_level_sel), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
        .wake_idle(wake_idle), .irq(irq), .mf_irq_req(mf_irq_req));
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // leaves time 1 ns past the edge so registered outputs have landed
    task automatic cyc(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask : cyc
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk("reg_rdata", exp, reg_rdata);
    endtask : rd
    // polls by selector so no reference argument is needed
    task automatic wait_hi(input bit pick_wake, output int c);
        logic seen;
        c = 0;
        seen = pick_wake ? wake_idle : mf_irq_req;
        while (seen !== 1'b1 && c < 40)
        begin
            cyc(1);
            c++;
            seen = pick_wake ? wake_idle : mf_irq_req;
        end
        if (seen !== 1'b1)
        begin
            err_count++;
            $display("unexpected timeout: expected 1 seen %b", seen);
            results();
        end
    endtask : wait_hi
    initial
    begin
        forever #2 clock = ~clock;
    end
    initial
    begin
        cyc(10);
        reset <= 1'b0;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h00);
        chk("detector_enable", 8'h00, {7'h00, detector_enable});
        wr(2'h0, 8'hef);
        rd(2'h0, 8'h07);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h00);
        for (i = 0; i < 8; i++)
        begin
            wr(2'h0, 8'h10 | 8'(i));
            rd(2'h0, 8'h10 | 8'(i));
            chk("trip_level_sel", 8'(i), {5'h00, trip_level_sel});
        end
        $display("test registers done");
        cyc(12);
        @(posedge clock);
        cmp_async <= 1'b1;
        wait_hi(1'b0, n);
        chk("irq_delay", 8'h01, {7'h00, n >= 7});
        rd(2'h0, 8'h37);
        rd(2'h1, 8'h03);
        chk("irq", 8'h00, {7'h00, irq});
        wr(2'h2, 8'h01);
        cyc(2);
        chk("irq", 8'h01, {7'h00, irq});
        wr(2'h1, 8'h01);
        cyc(2);
        rd(2'h1, 8'h02);
        chk("irq", 8'h00, {7'h00, irq});
        wr(2'h2, 8'h02);
        cyc(2);
        chk("irq", 8'h01, {7'h00, irq});
        wr(2'h2, 8'h00);
        cyc(2);
        chk("irq", 8'h00, {7'h00, irq});
        @(posedge clock);
        cmp_async <= 1'b0;
        cyc(8);
        rd(2'h0, 8'h17);
        // pulses shorter than the delay must never raise the request
        repeat (12)
        begin
            cyc(1);
            @(posedge clock);
            cmp_async <= ~cmp_async;
        end
        cyc(6);
        rd(2'h1, 8'h02);
        $display("test flag done");
        wr(2'h1, 8'h03);
        @(posedge clock);
        sleep_mode <= 1'b1;
        cmp_async <= 1'b1;
        cyc(6);
        chk("detector_enable", 8'h00, {7'h00, detector_enable});
        rd(2'h0, 8'h17);
        @(posedge clock);
        sleep_mode <= 1'b0;
        wr(2'h0, 8'h07);
        cyc(6);
        rd(2'h0, 8'h07);
        chk("detector_enable", 8'h00, {7'h00, detector_enable});
        $display("test power done");
        @(posedge clock);
        cmp_async <= 1'b0;
        wr(2'h1, 8'h03);
        wr(2'h0, 8'h10);
        cyc(12);
        @(posedge clock);
        idle_mode <= 1'b1;
        cmp_async <= 1'b1;
        wait_hi(1'b1, n);
        chk("wake_idle", 8'h01, {7'h00, wake_idle});
        @(posedge clock);
        cmp_async <= 1'b0;
        cyc(8);
        @(posedge clock);
        cmp_async <= 1'b1;
        n = 0;
        for (i = 0; i < 20; i++)
        begin
            cyc(1);
            if (wake_idle === 1'b1)
                n++;
        end
        chk("wake_count", 8'h00, 8'(n));
        $display("test wake done");
        // load state that reset must clear, then reset in mid-run
        wr(2'h2, 8'h03);
        wr(2'h0, 8'h05);
        cyc(2);
        chk("irq", 8'h01, {7'h00, irq});
        @(posedge clock);
        reset <= 1'b1;
        cyc(3);
        chk("reset_outputs", 8'h00, {2'h0, trip_level_sel, detector_enable, irq, mf_irq_req});
        @(posedge clock);
        reset <= 1'b0;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h00);
        $display("test reset done");
        results();
    end
endmodule : tb_svmon_top
bind svmon_top svmon_top_chk #(.SETTLE_CYCLES(SETTLE_CYCLES),
    .IRQ_DELAY_CYCLES(IRQ_DELAY_CYCLES)) u_chk (
    .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .cmp_async(cmp_async), .detector_enable(detector_enable),
    .trip_level_sel(trip_level_sel), .sleep_mode(sleep_mode), .idle_mode(idle_mode),
    .wake_idle(wake_idle), .irq(irq), .mf_irq_req(mf_irq_req));
